// >>> hdl/cai_pkg.sv
/*
 * constants, opcodes and state types for the cnc arc and loop
 * interpreter; assumes ascii command characters on a same-clock link.
 */
package cai_pkg;

	// ----------------------------------------------------------------
	// link characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_DIR   = 8'h66; // circle direction
	localparam logic [7:0] CH_ARC   = 8'h79; // circular interpolation
	localparam logic [7:0] CH_LOOP  = 8'h33; // loop or branch
	localparam logic [7:0] CH_CR    = 8'h0d; // command end
	localparam logic [7:0] CH_COMMA = 8'h2c; // argument separator
	localparam logic [7:0] CH_MINUS = 8'h2d; // negative sign
	localparam logic [7:0] CH_ZERO  = 8'h30; // digit 0, handshake
	localparam logic [7:0] CH_NINE  = 8'h39; // digit 9
	localparam logic [7:0] CH_ERR   = 8'h31; // refusal reply

	// ----------------------------------------------------------------
	// argument layout and limits
	// ----------------------------------------------------------------
	localparam int NUM_W      = 32;    // argument width
	localparam int ARG_MAX    = 7;     // most arguments per command
	localparam int DIR_ARGS   = 1;     // direction arguments
	localparam int ARC_ARGS   = 7;     // arc arguments
	localparam int LOOP_ARGS  = 2;     // loop arguments
	localparam int LOOP_MAX   = 32768; // loop count and offset bound
	localparam int LOOP_DEPTH = 15;    // nesting depth
	localparam int CNT_W      = 15;    // loop counter width
	localparam int PROG_DEPTH = 256;   // stored commands
	localparam logic RST_CCW  = 1'b0;  // clockwise after reset

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum {OP_DIR, OP_ARC, OP_LOOP} cai_op_e;
	typedef enum {PS_IDLE, PS_ARGS} cai_ps_e;
	typedef enum {EX_IDLE, EX_FETCH, EX_DECODE, EX_ARC} cai_ex_e;

endpackage : cai_pkg

// >>> hdl/cai_num_acc.sv
/*
 * signed decimal accumulator for one command argument;
 * assumes digits arrive most significant first.
 */
`timescale 1ns/10ps
module cai_num_acc import cai_pkg::*; #(
	parameter int W = NUM_W
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// character strobes
	input  wire logic                clr,
	input  wire logic                dig_v,
	input  wire logic [3:0]          dig,
	input  wire logic                neg_v,
	// running value
	output logic signed [W-1:0]      value
);

	logic [W-1:0] mag_q; // magnitude so far
	logic         neg_q; // minus seen

	// ----------------------------------------------------------------
	// magnitude: times ten plus digit
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mag_q <= '0;
		end else if (clr) begin
			mag_q <= '0;
		end else if (dig_v) begin
			mag_q <= W'(mag_q * W'(10) + W'(dig));
		end
	end

	// sign flag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			neg_q <= 1'b0;
		end else if (clr) begin
			neg_q <= 1'b0;
		end else if (neg_v) begin
			neg_q <= 1'b1;
		end
	end

	assign value = neg_q ? -$signed(mag_q) : $signed(mag_q);

endmodule : cai_num_acc

// >>> hdl/cai_loop_stk.sv
/*
 * loop counter stack: count and owning command address per level;
 * assumes push, pop and dec are never asked together.
 */
`timescale 1ns/10ps
module cai_loop_stk import cai_pkg::*; #(
	parameter int DEPTH = LOOP_DEPTH,
	parameter int CW    = CNT_W,
	parameter int PW    = 9
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst,
	// operations
	input  wire logic          clr,
	input  wire logic          push,
	input  wire logic          pop,
	input  wire logic          dec,
	input  wire logic [CW-1:0] push_cnt,
	input  wire logic [PW-1:0] push_addr,
	// top of stack
	output logic [CW-1:0]      top_cnt,
	output logic [PW-1:0]      top_addr,
	output logic [4:0]         level,
	output logic               full,
	output logic               empty
);

	logic [CW-1:0] cnt_q [DEPTH]; // counters
	logic [PW-1:0] adr_q [DEPTH]; // loop command addresses
	logic [4:0]    lvl_q;         // entries in use
	logic [3:0]    top;           // index of top entry

	assign level = lvl_q;
	assign full  = lvl_q == 5'(DEPTH);
	assign empty = lvl_q == 5'd0;
	assign top   = 4'(lvl_q - 5'd1);
	assign top_cnt  = cnt_q[top];
	assign top_addr = adr_q[top];

	// ----------------------------------------------------------------
	// level: full refuses push, never overwrites
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lvl_q <= 5'd0;
		end else if (clr) begin
			lvl_q <= 5'd0;
		end else if (push && !full) begin
			lvl_q <= lvl_q + 5'd1;
		end else if (pop && !empty) begin
			lvl_q <= lvl_q - 5'd1;
		end
	end

	// entry contents
	always_ff @(posedge ref_clk) begin
		if (push && !full) begin
			cnt_q[4'(lvl_q)] <= push_cnt;
			adr_q[4'(lvl_q)] <= push_addr;
		end else if (dec && !empty) begin
			cnt_q[top] <= cnt_q[top] - CW'(1);
		end
	end

endmodule : cai_loop_stk

// >>> hdl/cai_interp.sv
/*
 * command interpreter: parses direction, arc and loop commands,
 * stores them and runs the stored program with a loop stack.
 * assumes characters and handshakes on ref_clk from nearby logic.
 */
`timescale 1ns/10ps
module cai_interp import cai_pkg::*; #(
	parameter int DEPTH = PROG_DEPTH
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// received characters
	input  wire logic [7:0]        rx_data,
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	// reply character
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready,
	// program control
	input  wire logic              prog_clear,
	input  wire logic              exec_start,
	output logic                   exec_busy,
	output logic                   exec_error,
	// arc to step generator
	output logic                   arc_valid,
	input  wire logic              arc_ready,
	output logic                   arc_ccw,
	output logic signed [31:0]     arc_length,
	output logic signed [31:0]     arc_velocity,
	output logic signed [31:0]     arc_param,
	output logic signed [31:0]     start_offset_x,
	output logic signed [31:0]     start_offset_y,
	output logic signed [31:0]     quadrant_sign_x,
	output logic signed [31:0]     quadrant_sign_y
);

	localparam int AW = $clog2(DEPTH); // memory index width
	localparam int PW = AW + 1;        // counter with end room

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	cai_ps_e            ps_q;               // parser state
	cai_op_e            op_q;               // command being parsed
	logic [2:0]         fidx_q;             // current argument
	logic               bad_q;              // malformed command
	logic signed [31:0] fld_q [ARG_MAX];    // finished arguments
	logic signed [31:0] fin [ARG_MAX];      // arguments incl. current
	logic signed [31:0] num_val;            // current argument
	logic               take;               // character accepted
	logic               is_dig;             // character is digit
	logic               at_cr;              // command end accepted
	logic               cmd_ok;             // arguments valid
	logic               wr_en;              // store command
	logic               tx_valid_q;         // reply pending
	logic [7:0]         tx_data_q;          // reply character
	cai_op_e            mem_op [DEPTH];     // stored opcodes
	logic signed [31:0] mem_fld [DEPTH][ARG_MAX]; // stored args
	logic [PW-1:0]      wp_q;               // stored command count
	logic               mem_full;           // no room
	cai_ex_e            ex_q;               // execution state
	logic [PW-1:0]      pc_q;               // command counter
	cai_op_e            e_op_q;             // fetched opcode
	logic signed [31:0] e_f_q [ARG_MAX];    // fetched arguments
	logic signed [31:0] tgt;                // absolute target, signed
	logic [PW-1:0]      tgt_pc;             // target as counter
	logic               tgt_bad;            // target off program
	logic               is_loop;            // loop command decoded
	logic               is_branch;          // branch decoded
	logic               revisit;            // loop already stacked
	logic               stk_push;           // new loop level
	logic               stk_pop;            // loop finished
	logic               stk_dec;            // one pass done
	logic               overflow;           // nesting too deep
	logic [CNT_W-1:0]   stk_cnt;            // top counter
	logic [PW-1:0]      stk_addr;           // top owner
	logic [4:0]         stk_level;          // nesting in use
	logic               stk_full;           // stack full
	logic               stk_empty;          // stack empty
	logic               arc_valid_q;        // arc offered
	logic               arc_ccw_q;          // direction
	logic               err_q;              // execution fault
	logic signed [31:0] arc_q [ARG_MAX];    // arc outputs

	// ----------------------------------------------------------------
	// argument checks per command
	// ----------------------------------------------------------------
	function automatic logic args_ok(cai_op_e op, logic [2:0] n,
		logic signed [31:0] a0, logic signed [31:0] a1);
		case (op)
			OP_DIR: begin
				args_ok = n == 3'(DIR_ARGS - 1)
					&& (a0 == 0 || a0 == -1);
			end
			OP_ARC: begin
				args_ok = n == 3'(ARC_ARGS - 1);
			end
			default: begin
				args_ok = n == 3'(LOOP_ARGS - 1) && (a0 == 0
					|| (a0 > 0 && a0 < LOOP_MAX
					&& a1 < 0 && a1 >= -LOOP_MAX));
			end
		endcase
	endfunction : args_ok

	// ----------------------------------------------------------------
	// parser
	// ----------------------------------------------------------------
	assign rx_ready = !tx_valid_q;
	assign take     = rx_valid && rx_ready;
	assign is_dig   = rx_data >= CH_ZERO && rx_data <= CH_NINE;
	assign at_cr    = take && ps_q == PS_ARGS && rx_data == CH_CR;
	assign mem_full = wp_q == PW'(DEPTH);
	assign cmd_ok   = args_ok(op_q, fidx_q, fin[0], fin[1]) && !bad_q;
	assign wr_en    = at_cr && cmd_ok && !mem_full;

	// current argument joins the finished ones
	for (genvar i = 0; i < ARG_MAX; i++) begin : g_fin
		assign fin[i] = (fidx_q == 3'(i)) ? num_val : fld_q[i];
	end

	// decimal accumulator
	cai_num_acc #(
		.W     (32)
	) u_num (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clr     (take && (ps_q == PS_IDLE || rx_data == CH_COMMA)),
		.dig_v   (take && ps_q == PS_ARGS && is_dig),
		.dig     (rx_data[3:0]),
		.neg_v   (take && ps_q == PS_ARGS && rx_data == CH_MINUS),
		.value   (num_val)
	);

	// parser state and opcode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ps_q <= PS_IDLE;
			op_q <= OP_DIR;
		end else if (take && ps_q == PS_IDLE) begin
			// other command letters are ignored and the parser stays idle
			if (rx_data == CH_DIR) begin
				ps_q <= PS_ARGS;
				op_q <= OP_DIR;
			end else if (rx_data == CH_ARC) begin
				ps_q <= PS_ARGS;
				op_q <= OP_ARC;
			end else if (rx_data == CH_LOOP) begin
				ps_q <= PS_ARGS;
				op_q <= OP_LOOP;
			end
		end else if (at_cr) begin
			ps_q <= PS_IDLE;
		end
	end

	// argument index, overflow marks the command bad
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fidx_q <= 3'd0;
			bad_q  <= 1'b0;
		end else if (take && ps_q == PS_IDLE) begin
			fidx_q <= 3'd0;
			bad_q  <= 1'b0;
		end else if (take && rx_data == CH_COMMA) begin
			if (fidx_q == 3'(ARG_MAX - 1)) begin
				bad_q <= 1'b1;
			end else begin
				fidx_q <= fidx_q + 3'd1;
			end
		end
	end

	// finished arguments
	always_ff @(posedge ref_clk) begin
		if (take && ps_q == PS_ARGS && rx_data == CH_COMMA) begin
			fld_q[fidx_q] <= num_val;
		end
	end

	// reply: zero when stored, refusal otherwise
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_valid_q <= 1'b0;
			tx_data_q  <= CH_ZERO;
		end else if (at_cr) begin
			tx_valid_q <= 1'b1;
			tx_data_q  <= wr_en ? CH_ZERO : CH_ERR;
		end else if (tx_ready) begin
			tx_valid_q <= 1'b0;
		end
	end
	assign tx_valid = tx_valid_q;
	assign tx_data  = tx_data_q;

	// ----------------------------------------------------------------
	// program store
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
		end else if (prog_clear && ex_q == EX_IDLE) begin
			wp_q <= '0;
		end else if (wr_en) begin
			wp_q <= wp_q + PW'(1);
		end
	end

	// command memory; arcs stored unchecked for travel
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_op[wp_q[AW-1:0]] <= op_q;
			for (int i = 0; i < ARG_MAX; i++) begin
				mem_fld[wp_q[AW-1:0]][i] <= fin[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// loop and branch decode
	// ----------------------------------------------------------------
	assign tgt     = signed'(32'(pc_q)) + e_f_q[1];
	assign tgt_pc  = tgt[PW-1:0];
	assign tgt_bad = tgt < 0 || tgt >= signed'(32'(wp_q));
	assign is_loop   = ex_q == EX_DECODE && e_op_q == OP_LOOP;
	assign is_branch = is_loop && e_f_q[0] == 0;
	assign revisit   = !stk_empty && stk_addr == pc_q;
	assign overflow  = is_loop && !is_branch && !revisit && stk_full;

	// stack requests
	always_comb begin
		stk_push = 1'b0;
		stk_pop  = 1'b0;
		stk_dec  = 1'b0;
		if (is_loop && !is_branch) begin
			if (revisit) begin
				// last pass pops, others count down
				stk_pop = stk_cnt == CNT_W'(1);
				stk_dec = stk_cnt != CNT_W'(1);
			end else begin
				stk_push = !stk_full && !tgt_bad;
			end
		end
	end

	cai_loop_stk #(
		.DEPTH (LOOP_DEPTH),
		.CW    (CNT_W),
		.PW    (PW)
	) u_stk (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clr       (exec_start && ex_q == EX_IDLE),
		.push      (stk_push),
		.pop       (stk_pop),
		.dec       (stk_dec),
		.push_cnt  (e_f_q[0][CNT_W-1:0]),
		.push_addr (pc_q),
		.top_cnt   (stk_cnt),
		.top_addr  (stk_addr),
		.level     (stk_level),
		.full      (stk_full),
		.empty     (stk_empty)
	);

	// ----------------------------------------------------------------
	// execution sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ex_q <= EX_IDLE;
			pc_q <= '0;
		end else begin
			case (ex_q)
				EX_IDLE: begin
					if (exec_start) begin
						ex_q <= EX_FETCH;
						pc_q <= '0;
					end
				end
				EX_FETCH: begin
					// running past the last command ends the run
					ex_q <= (pc_q >= wp_q) ? EX_IDLE : EX_DECODE;
				end
				EX_DECODE: begin
					ex_q <= EX_FETCH;
					pc_q <= pc_q + PW'(1);
					if (e_op_q == OP_ARC) begin
						ex_q <= EX_ARC;
						pc_q <= pc_q;
					end else if (overflow) begin
						ex_q <= EX_IDLE;
					end else if (is_loop && !stk_pop) begin
						// jump unless the target is off the program
						ex_q <= tgt_bad ? EX_IDLE : EX_FETCH;
						pc_q <= tgt_pc;
					end
				end
				default: begin
					if (arc_ready) begin
						ex_q <= EX_FETCH;
						pc_q <= pc_q + PW'(1);
					end
				end
			endcase
		end
	end

	// fetch stage read
	always_ff @(posedge ref_clk) begin
		if (ex_q == EX_FETCH) begin
			e_op_q <= mem_op[pc_q[AW-1:0]];
			for (int i = 0; i < ARG_MAX; i++) begin
				e_f_q[i] <= mem_fld[pc_q[AW-1:0]][i];
			end
		end
	end

	// fault flag, cleared by the next start
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (overflow || (is_loop && !stk_pop && tgt_bad)) begin
			err_q <= 1'b1;
		end else if (exec_start && ex_q == EX_IDLE) begin
			err_q <= 1'b0;
		end
	end
	assign exec_busy  = ex_q != EX_IDLE;
	assign exec_error = err_q;

	// ----------------------------------------------------------------
	// arc output
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arc_ccw_q <= RST_CCW;
		end else if (ex_q == EX_DECODE && e_op_q == OP_DIR) begin
			arc_ccw_q <= e_f_q[0] != 0;
		end
	end

	// arc offer and fields; host programs direction first
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arc_valid_q <= 1'b0;
			for (int i = 0; i < ARG_MAX; i++) begin
				arc_q[i] <= '0;
			end
		end else if (ex_q == EX_DECODE && e_op_q == OP_ARC) begin
			arc_valid_q <= 1'b1;
			for (int i = 0; i < ARG_MAX; i++) begin
				arc_q[i] <= e_f_q[i];
			end
		end else if (arc_ready) begin
			arc_valid_q <= 1'b0;
		end
	end
	assign arc_valid       = arc_valid_q;
	assign arc_ccw         = arc_ccw_q;
	assign arc_length      = arc_q[0];
	assign arc_velocity    = arc_q[1];
	assign arc_param       = arc_q[2];
	assign start_offset_x  = arc_q[3];
	assign start_offset_y  = arc_q[4];
	assign quadrant_sign_x = arc_q[5];
	assign quadrant_sign_y = arc_q[6];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence reply_zero_s;
		tx_valid && tx_data == CH_ZERO;
	endsequence
	sequence halted_s;
		exec_error && !exec_busy;
	endsequence

	reply_zero_a: assert property (
		wr_en |=> reply_zero_s) else $error("no zero reply");
	dir_value_a: assert property (
		wr_en && op_q == OP_DIR |-> fin[0] == 0 || fin[0] == -1)
		else $error("bad direction stored");
	arc_fields_a: assert property (
		wr_en && op_q == OP_ARC |-> fidx_q == 3'd6)
		else $error("arc without seven fields");
	loop_range_a: assert property (
		wr_en && op_q == OP_LOOP && fin[0] != 0
		|-> fin[0] < LOOP_MAX && fin[1] < 0)
		else $error("loop out of range");
	branch_jump_a: assert property (
		is_branch && !tgt_bad |=> pc_q == $past(tgt_pc)
		&& ex_q == EX_FETCH) else $error("branch target wrong");
	branch_first_a: assert property (
		is_branch |-> !stk_push && !stk_pop && !stk_dec)
		else $error("branch touched stack");
	loop_push_a: assert property (
		stk_push |=> stk_level == $past(stk_level) + 5'd1
		&& pc_q == $past(tgt_pc)) else $error("loop push failed");
	overflow_stop_a: assert property (
		overflow |=> halted_s ##1 halted_s)
		else $error("overflow not halted");
	arc_start_a: assert property (
		ex_q == EX_DECODE && e_op_q == OP_ARC |=> arc_valid
		&& start_offset_x == $past(e_f_q[3])
		&& quadrant_sign_y == $past(e_f_q[6]))
		else $error("arc fields wrong");

endmodule : cai_interp

// >>> verification/cai_host_model.sv
/*
 * host model: sends ascii commands one char at a time and takes
 * the one-char reply; assumes the interpreter runs on ref_clk.
 */
`timescale 1ns/10ps
module cai_host_model (
	// clock
	input  wire logic       ref_clk,
	// char link
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// pacing and hang flag
	input  wire logic [1:0] slow,
	output logic            hang
);
	// idle link after time zero
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		hang = 1'b0;
	end
	// whole command, then reply with a slow consumer
	// direction first, host-made parameters, legal jumps
	// branches stay inside loops and program
	task automatic send(input string s, output logic [7:0] rep);
		int i;
		int k;
		rx_valid = 1'b1;
		for (i = 0; i < s.len(); i++) begin
			rx_data = s[i];
			for (k = 0; rx_ready !== 1'b1 && k < 50; k++)
				@(posedge ref_clk) #1;
			// a char link that never takes the char counts as a hang
			if (k == 50)
				hang = 1'b1;
			@(posedge ref_clk) #1;
		end
		rx_valid = 1'b0;
		rx_data = ~rx_data; // released line never shows the old char
		for (k = 0; tx_valid !== 1'b1 && k < 50; k++)
			@(posedge ref_clk) #1;
		hang = hang || (k == 50);
		rep = tx_data;
		repeat (slow) @(posedge ref_clk) #1;
		tx_ready = 1'b1;
		@(posedge ref_clk) #1;
		tx_ready = 1'b0;
	endtask : send
endmodule : cai_host_model

// >>> verification/tb.sv
/*
 * bench for the interpreter: stores programs, runs them and compares
 * replies, arcs and end state with an integer model; assumes the
 * host model drives the char link.
 */
`timescale 1ns/10ps
module tb import cai_pkg::*;;
	// design ports
	logic               ref_clk, rst, prog_clear, exec_start, arc_ready;
	logic               rx_valid, rx_ready, tx_valid, tx_ready, hang;
	logic               exec_busy, exec_error, arc_valid, arc_ccw;
	logic [7:0]         rx_data, tx_data, rep;
	logic [1:0]         slow;
	logic signed [31:0] arc_length, arc_velocity, arc_param;
	logic signed [31:0] start_offset_x, start_offset_y;
	logic signed [31:0] quadrant_sign_x, quadrant_sign_y;
	// model program: opcode, count, offset, arc fields
	int                 n_mismatch, checks_done, seed, n_cmd;
	int                 op[32], a0[32], a1[32];
	logic [223:0]       af[32];
	logic [224:0]       exp_q[$];
	logic               m_err;
	string              bad[4] = '{"f5\015", "y1,2,3\015",
		"31,4\015", "332768,-1\015"};

	cai_interp u_cai_interp (.ref_clk, .rst, .rx_data, .rx_valid,
		.rx_ready, .tx_data, .tx_valid, .tx_ready, .prog_clear,
		.exec_start, .exec_busy, .exec_error, .arc_valid, .arc_ready,
		.arc_ccw, .arc_length, .arc_velocity, .arc_param,
		.start_offset_x, .start_offset_y, .quadrant_sign_x,
		.quadrant_sign_y);
	cai_host_model host (.ref_clk, .rx_data, .rx_valid, .rx_ready,
		.tx_data, .tx_valid, .tx_ready, .slow, .hang);

	// 40 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// compare arcs and states
	task automatic chk_val(input logic [224:0] got, input logic [224:0] e);
		checks_done++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, e);
		end
	endtask : chk_val

	// compare reply chars
	task automatic chk_chr(input logic [7:0] got, input logic [7:0] e);
		chk_val({217'h0, got}, {217'h0, e});
	endtask : chk_chr

	// a stuck char link or reply ends the run
	always @(posedge hang) begin
		n_mismatch++;
		test_done();
	end

	// store one command and its model copy
	task automatic add(input string s, input int o, x, y,
		input logic [223:0] f);
		slow = 2'($random(seed));
		host.send(s, rep);
		chk_chr(rep, CH_ZERO);
		op[n_cmd] = o;
		a0[n_cmd] = x;
		a1[n_cmd] = y;
		af[n_cmd] = f;
		n_cmd++;
	endtask : add

	// arc with random fields, each below 1000 in magnitude
	task automatic add_arc();
		int v[7];
		foreach (v[i]) v[i] = $random(seed) % 1000;
		add($sformatf("y%0d,%0d,%0d,%0d,%0d,%0d,%0d\015", v[0], v[1],
			v[2], v[3], v[4], v[5], v[6]), 1, 0, 0,
			{v[0], v[1], v[2], v[3], v[4], v[5], v[6]});
	endtask : add_arc

	// empty the stored program
	task automatic clear();
		prog_clear = 1'b1;
		@(posedge ref_clk) #1;
		prog_clear = 1'b0;
		n_cmd = 0;
	endtask : clear

	// reference run with a loop stack of queues
	task automatic model_run();
		int pc;
		int cnt[$];
		int adr[$];
		logic ccw;
		pc = 0;
		ccw = 1'b0;
		m_err = 1'b0;
		while (pc < n_cmd && !m_err) begin
			if (op[pc] == 0) ccw = (a0[pc] != 0);
			if (op[pc] == 1) exp_q.push_back({ccw, af[pc]});
			if (op[pc] != 2) pc++;
			else if (a0[pc] == 0) pc += a1[pc];
			else if (adr.size() > 0 && adr[$] == pc) begin
				if (cnt[$] == 1) begin
					void'(cnt.pop_back());
					void'(adr.pop_back());
					pc++;
				end else begin
					cnt[$] = cnt[$] - 1;
					pc += a1[pc];
				end
			end else if (adr.size() == LOOP_DEPTH) m_err = 1'b1;
			else begin
				cnt.push_back(a0[pc]);
				adr.push_back(pc);
				pc += a1[pc];
			end
		end
	endtask : model_run

	// run the program, take arcs after a random stall
	task automatic run(input int id);
		int k;
		logic [224:0] e;
		model_run();
		exec_start = 1'b1;
		@(posedge ref_clk) #1;
		exec_start = 1'b0;
		for (k = 0; exec_busy === 1'b1 && k < 3000; k++) begin
			if (arc_valid === 1'b1) begin
				e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
				chk_val({arc_ccw, arc_length, arc_velocity, arc_param,
					start_offset_x, start_offset_y, quadrant_sign_x,
					quadrant_sign_y}, e);
				repeat (2'($random(seed))) @(posedge ref_clk) #1;
				arc_ready = 1'b1;
				@(posedge ref_clk) #1;
				arc_ready = 1'b0;
			end else
				@(posedge ref_clk) #1;
		end
		if (k == 3000) begin
			n_mismatch++;
			test_done();
		end
		chk_val(225'(exp_q.size()), 225'h0);
		chk_val({224'h0, exec_error}, {224'h0, m_err});
		$display("test %0d done", id);
	endtask : run

	// main sequence
	initial begin
		rst = 1'b1;
		prog_clear = 1'b0;
		exec_start = 1'b0;
		arc_ready = 1'b0;
		slow = 2'h0;
		seed = 32'h36d8;
		n_mismatch = 0;
		checks_done = 0;
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk_val({211'h0, rx_ready, tx_valid, tx_data, exec_busy,
			exec_error, arc_valid, arc_ccw}, {211'h0, 2'h2, CH_ZERO,
			4'h0});
		foreach (bad[i]) begin
			host.send(bad[i], rep);
			chk_chr(rep, CH_ERR);
		end
		$display("test 1 done");
		// loop, nested loop and forward branch over four arcs
		clear();
		add("f-1\015", 0, -1, 0, '0);
		add_arc();
		add("32,-1\015", 2, 2, -1, '0);
		add("f0\015", 0, 0, 0, '0);
		add("30,5\015", 2, 0, 5, '0);
		repeat (5) add_arc();
		add("31,-9\015", 2, 1, -9, '0);
		add_arc();
		run(2);
		// sixteen nested loops overflow the stack
		clear();
		add("30,16\015", 2, 0, 16, '0);
		repeat (16) add("31,-1\015", 2, 1, -1, '0);
		run(3);
		test_done();
	end
endmodule : tb
